//--- rtl/dsa_access_unit.sv
// data-space access unit: decode, lane steering, zero fill and alignment trap
// Contract
// - addresses are 16-bit byte addresses, 64 KB
// - bit 15 clear memory, set program-visibility
// - unimplemented locations read as zero
// - words little-endian: low byte at even
// - post-modify steps one per byte, two per word
// - byte read selects lane, delivered low
// - shared word decode, separate lane write strobes
// - odd word access raises address error trap
// - misaligned read still completes
// - misaligned write suppressed, trap raised in the same cycle
// - byte load keeps destination high byte
// - sign-extend and zero-extend of low byte
// - special registers fill first two kilobytes
// - unused special register addresses read zero
// - near field reaches up to 0x1FFF
// - move forms reach whole data space
// - read and write served independently
`timescale 1ns/1ps
module dsa_access_unit (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire dsa_pkg::dsa_rd_req_t rd_req_in,
	input wire dsa_pkg::dsa_wr_req_t wr_req_in,
	output dsa_pkg::dsa_rd_rsp_t rd_rsp_out,
	output logic [15:0] rd_ptr_next_out,
	output logic [15:0] wr_ptr_next_out,
	output dsa_pkg::dsa_sfr_rd_t sfr_rd_out,
	input wire logic [15:0] sfr_rdata_in,
	input wire logic sfr_ack_in,
	output dsa_pkg::dsa_sfr_wr_t sfr_wr_out,
	output dsa_pkg::dsa_trap_t trap_out
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// effective address from the addressing form
	function automatic logic [15:0] ea_of(input dsa_pkg::dsa_mode_t m, input logic [15:0] f);
		logic [15:0] r;
		r = f;
		if (m == dsa_pkg::AM_NEAR13)
			r = {3'h0, f[dsa_pkg::NEAR_W-1:0]};
		return r;
	endfunction

	// region decode shared by both address generation units
	function automatic dsa_pkg::dsa_region_t region_of(input logic [15:0] a);
		dsa_pkg::dsa_region_t r;
		if (a[dsa_pkg::PSV_BIT])
			r = dsa_pkg::RGN_PSV;
		else if (a <= dsa_pkg::SFR_LAST)
			r = dsa_pkg::RGN_SFR;
		else if (a >= dsa_pkg::RAM_FIRST && a <= dsa_pkg::RAM_LAST)
			r = dsa_pkg::RGN_RAM;
		else
			r = dsa_pkg::RGN_NONE;
		return r;
	endfunction

	// pointer step by access size
	function automatic logic [15:0] step_of(input logic [15:0] p, input logic b);
		return p + (b ? dsa_pkg::STEP_BYTE : dsa_pkg::STEP_WORD);
	endfunction

	// ----------------------------------------
	// decode of both requests
	// ----------------------------------------
	logic [15:0] rd_ea;
	logic [15:0] wr_ea;
	dsa_pkg::dsa_region_t rd_rgn;
	dsa_pkg::dsa_region_t wr_rgn;
	logic rd_mis;
	logic wr_mis;
	logic wr_lo;
	logic wr_hi;
	logic [15:0] wr_lane_data;

	// word address is shared, lanes are split by bit 0
	always_comb
	begin
		rd_ea = ea_of(rd_req_in.mode, rd_req_in.field);
		wr_ea = ea_of(wr_req_in.mode, wr_req_in.field);
		rd_rgn = region_of(rd_ea);
		wr_rgn = region_of(wr_ea);
		rd_mis = rd_req_in.valid && !rd_req_in.is_byte && rd_ea[0];
		wr_mis = wr_req_in.valid && !wr_req_in.is_byte && wr_ea[0];
		// misaligned write executes but never touches storage
		wr_lo = wr_req_in.valid && !wr_mis && (!wr_req_in.is_byte || !wr_ea[0]);
		wr_hi = wr_req_in.valid && !wr_mis && (!wr_req_in.is_byte || wr_ea[0]);
		// byte data rides the low byte and is copied to both lanes
		if (wr_req_in.is_byte)
			wr_lane_data = {wr_req_in.data[7:0], wr_req_in.data[7:0]};
		else
			wr_lane_data = wr_req_in.data;
	end

	// trap pulse only on a strobed misaligned word access
	always_comb
	begin
		trap_out.pulse = rd_mis || wr_mis;
		trap_out.on_write = wr_mis;
		trap_out.addr = wr_mis ? wr_ea : rd_ea;
		sfr_rd_out.en = rd_req_in.valid && rd_rgn == dsa_pkg::RGN_SFR;
		sfr_rd_out.word_addr = rd_ea[10:1];
	end

	// ----------------------------------------
	// data memory, two byte-wide halves
	// ----------------------------------------
	logic [7:0] ram_lo [dsa_pkg::RAM_WORDS];
	logic [7:0] ram_hi [dsa_pkg::RAM_WORDS];
	logic [15:0] ram_word_q;
	logic ram_wr_lo;
	logic ram_wr_hi;

	// read-before-write, so a read and write to one word see the old value
	always_comb
	begin
		ram_wr_lo = wr_lo && wr_rgn == dsa_pkg::RGN_RAM;
		ram_wr_hi = wr_hi && wr_rgn == dsa_pkg::RGN_RAM;
	end

	// lanes written on their own strobes; the read word is registered for the answer cycle
	always_ff @(posedge clk_sys_in)
	begin
		if (ram_wr_lo)
			ram_lo[wr_ea[10:1]] <= wr_lane_data[7:0];
		if (ram_wr_hi)
			ram_hi[wr_ea[10:1]] <= wr_lane_data[15:8];
		ram_word_q <= {ram_hi[rd_ea[10:1]], ram_lo[rd_ea[10:1]]};
	end

	// ----------------------------------------
	// read stage, pointer updates and register writes
	// ----------------------------------------
	logic rv_q, rv_d;
	logic rb_q, rb_d;
	logic ra0_q, ra0_d;
	dsa_pkg::dsa_region_t rr_q, rr_d;
	dsa_pkg::dsa_ext_t rx_q, rx_d;
	logic [15:0] rold_q, rold_d;
	logic [15:0] rptr_q, rptr_d;
	logic [15:0] wptr_q, wptr_d;
	dsa_pkg::dsa_sfr_wr_t sw_q, sw_d;

	// misaligned reads still complete, returning the containing word
	always_comb
	begin
		rv_d = rd_req_in.valid;
		rb_d = rd_req_in.is_byte;
		ra0_d = rd_ea[0];
		rr_d = rd_rgn;
		rx_d = rd_req_in.ext;
		rold_d = rd_req_in.dest_old;
		rptr_d = rptr_q;
		if (rd_req_in.valid && rd_req_in.post_inc)
			rptr_d = step_of(rd_ea, rd_req_in.is_byte);
		wptr_d = wptr_q;
		if (wr_req_in.valid && wr_req_in.post_inc)
			wptr_d = step_of(wr_ea, wr_req_in.is_byte);
		sw_d.we_lo = wr_lo && wr_rgn == dsa_pkg::RGN_SFR;
		sw_d.we_hi = wr_hi && wr_rgn == dsa_pkg::RGN_SFR;
		sw_d.word_addr = wr_ea[10:1];
		sw_d.data = wr_lane_data;
	end

	// stage registers; reset clears the answer, pointers and register-port strobes
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			rv_q <= 1'b0;
			rb_q <= 1'b0;
			ra0_q <= 1'b0;
			rr_q <= dsa_pkg::RGN_NONE;
			rx_q <= dsa_pkg::EXT_NONE;
			rold_q <= dsa_pkg::DATA_RST;
			rptr_q <= dsa_pkg::DATA_RST;
			wptr_q <= dsa_pkg::DATA_RST;
			sw_q <= '0;
		end
		else
		begin
			rv_q <= rv_d;
			rb_q <= rb_d;
			ra0_q <= ra0_d;
			rr_q <= rr_d;
			rx_q <= rx_d;
			rold_q <= rold_d;
			rptr_q <= rptr_d;
			wptr_q <= wptr_d;
			sw_q <= sw_d;
		end
	end

	// pointers and register-port writes leave straight from flops
	assign rd_ptr_next_out = rptr_q;
	assign wr_ptr_next_out = wptr_q;
	assign sfr_wr_out = sw_q;

	// ----------------------------------------
	// answer: region select, lane select, load merge
	// ----------------------------------------
	logic [15:0] word_sel;
	logic [15:0] val_sel;
	logic [15:0] wreg_v;

	// stage flops, the registered array outputs and the register-port answer inputs feed this mux
	always_comb
	begin
		case (rr_q)
			dsa_pkg::RGN_RAM: word_sel = ram_word_q;
			dsa_pkg::RGN_SFR: word_sel = sfr_ack_in ? sfr_rdata_in : dsa_pkg::DATA_RST;
			default: word_sel = dsa_pkg::DATA_RST;
		endcase
		if (rb_q)
			val_sel = {8'h00, ra0_q ? word_sel[15:8] : word_sel[7:0]};
		else
			val_sel = word_sel;
		wreg_v = rb_q ? {rold_q[15:8], val_sel[7:0]} : val_sel;
		case (rx_q)
			dsa_pkg::EXT_SIGN: wreg_v = {{8{wreg_v[7]}}, wreg_v[7:0]};
			dsa_pkg::EXT_ZERO: wreg_v = {8'h00, wreg_v[7:0]};
			default: wreg_v = wreg_v;
		endcase
		rd_rsp_out.valid = rv_q;
		rd_rsp_out.region = rr_q;
		rd_rsp_out.data = rv_q ? val_sel : dsa_pkg::DATA_RST;
		rd_rsp_out.wreg = rv_q ? wreg_v : dsa_pkg::DATA_RST;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	// alignment trap: judged from the raw field bit, every addressing form keeps bit 0
	a_trap_odd_word: assert property (trap_out.pulse ==
		((rd_req_in.valid && !rd_req_in.is_byte && rd_req_in.field[0])
		|| (wr_req_in.valid && !wr_req_in.is_byte && wr_req_in.field[0])))
		else $error("trap pulse does not match misaligned word access");
	a_trap_strobed: assert property (trap_out.pulse
		|-> (rd_req_in.valid || wr_req_in.valid))
		else $error("trap pulse without an access strobe");
	a_trap_write: assert property (wr_req_in.valid && !wr_req_in.is_byte
		&& wr_req_in.field[0] |-> trap_out.on_write && trap_out.addr == wr_ea)
		else $error("write trap lost its side or address");
	a_wr_suppress: assert property (wr_mis |-> !ram_wr_lo && !ram_wr_hi
		##1 !sfr_wr_out.we_lo && !sfr_wr_out.we_hi)
		else $error("misaligned write reached storage");
	a_rd_completes: assert property (rd_mis |=> rd_rsp_out.valid)
		else $error("misaligned read did not complete");
	a_rd_one_answer: assert property (rd_rsp_out.valid |-> $past(rd_req_in.valid))
		else $error("read answer without a request");

	// zero fill for the reserved half, the holes and unused register slots
	a_psv_zero: assert property (rd_req_in.valid && rd_ea[15]
		|=> rd_rsp_out.data == 16'h0000)
		else $error("program-visibility read returned nonzero");
	a_hole_zero: assert property (rd_req_in.valid && rd_rgn == dsa_pkg::RGN_NONE
		|=> rd_rsp_out.data == 16'h0000)
		else $error("unimplemented read returned nonzero");
	a_sfr_unused: assert property (rd_rsp_out.valid && rr_q == dsa_pkg::RGN_SFR
		&& !sfr_ack_in |-> rd_rsp_out.data == 16'h0000)
		else $error("unused register address returned nonzero");

	// lanes and pointer steps
	a_sfr_word_wr: assert property (wr_req_in.valid && !wr_req_in.is_byte
		&& !wr_req_in.field[0] && wr_rgn == dsa_pkg::RGN_SFR |=> sfr_wr_out.we_lo && sfr_wr_out.we_hi)
		else $error("aligned register word write missed a lane");
	a_byte_one_lane: assert property (wr_req_in.valid && wr_req_in.is_byte
		|-> (wr_lo ^ wr_hi) && (wr_hi == wr_ea[0]))
		else $error("byte write did not hit exactly its own lane");
	a_ptr_step: assert property (rd_req_in.valid && rd_req_in.post_inc
		|=> rd_ptr_next_out == $past(rd_ea) + ($past(rd_req_in.is_byte) ? 16'h0001 : 16'h0002))
		else $error("read pointer stepped by the wrong amount");
	a_wr_ptr_step: assert property (wr_req_in.valid && wr_req_in.post_inc
		|=> wr_ptr_next_out == $past(wr_ea) + ($past(wr_req_in.is_byte) ? 16'h0001 : 16'h0002))
		else $error("write pointer stepped by the wrong amount");

	// load merge and extension
	a_byte_keep_hi: assert property (rd_rsp_out.valid && rb_q && rx_q == dsa_pkg::EXT_NONE
		|-> rd_rsp_out.wreg == {rold_q[15:8], rd_rsp_out.data[7:0]})
		else $error("byte load disturbed the high byte");
	a_byte_lane_sel: assert property (rd_req_in.valid && rd_req_in.is_byte
		|=> rd_rsp_out.data[15:8] == 8'h00)
		else $error("byte read left data in the high byte");
	a_sign_extend: assert property (rd_rsp_out.valid && rx_q == dsa_pkg::EXT_SIGN
		|-> rd_rsp_out.wreg[15:8] == {8{rd_rsp_out.wreg[7]}})
		else $error("sign extension wrong");
	a_zero_extend: assert property (rd_rsp_out.valid && rx_q == dsa_pkg::EXT_ZERO
		|-> rd_rsp_out.wreg[15:8] == 8'h00)
		else $error("zero extension left a high byte");
	a_near_field: assert property (rd_req_in.mode == dsa_pkg::AM_NEAR13
		|-> rd_ea <= dsa_pkg::NEAR_LAST)
		else $error("near address outside its window");

	// main scenarios: byte read, dropped write, reserved half, same-word clash, unused slot
	c_byte_read: cover property (rd_req_in.valid && rd_req_in.is_byte ##1 rd_rsp_out.valid);
	c_mis_write: cover property (wr_mis);
	c_psv_read: cover property (rd_req_in.valid && rd_rgn == dsa_pkg::RGN_PSV);
	c_both: cover property (rd_req_in.valid && wr_req_in.valid && rd_ea[10:1] == wr_ea[10:1]);
	c_sfr_unused: cover property (rd_rsp_out.valid && rr_q == dsa_pkg::RGN_SFR && !sfr_ack_in);

endmodule // dsa_access_unit

//--- rtl/dsa_pkg.sv
// package: constants, types and carriers for the data-space access unit
package dsa_pkg;

	// ----------------------------------------
	// address map
	// ----------------------------------------
	localparam int ADDR_W = 16;
	localparam logic [15:0] SFR_FIRST = 16'h0000;
	localparam logic [15:0] SFR_LAST = 16'h07FF;
	localparam logic [15:0] RAM_FIRST = 16'h0800;
	localparam logic [15:0] RAM_LAST = 16'h0FFF;
	localparam logic [15:0] NEAR_LAST = 16'h1FFF;
	localparam int NEAR_W = 13;
	localparam int PSV_BIT = 15;
	localparam int WORD_AW = 10;
	localparam int RAM_WORDS = 1024;

	// ----------------------------------------
	// steps and reset values
	// ----------------------------------------
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [15:0] DATA_RST = 16'h0000;

	// ----------------------------------------
	// enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {AM_DIRECT16, AM_NEAR13, AM_INDIRECT} dsa_mode_t;
	typedef enum logic [1:0] {EXT_NONE, EXT_SIGN, EXT_ZERO} dsa_ext_t;
	typedef enum logic [1:0] {RGN_SFR, RGN_RAM, RGN_NONE, RGN_PSV} dsa_region_t;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		dsa_mode_t mode;
		logic [15:0] field;
		logic post_inc;
		logic is_byte;
		dsa_ext_t ext;
		logic [15:0] dest_old;
	} dsa_rd_req_t;

	typedef struct packed {
		logic valid;
		dsa_mode_t mode;
		logic [15:0] field;
		logic post_inc;
		logic is_byte;
		logic [15:0] data;
	} dsa_wr_req_t;

	typedef struct packed {
		logic valid;
		dsa_region_t region;
		logic [15:0] data;
		logic [15:0] wreg;
	} dsa_rd_rsp_t;

	typedef struct packed {
		logic en;
		logic [9:0] word_addr;
	} dsa_sfr_rd_t;

	typedef struct packed {
		logic we_lo;
		logic we_hi;
		logic [9:0] word_addr;
		logic [15:0] data;
	} dsa_sfr_wr_t;

	typedef struct packed {
		logic pulse;
		logic on_write;
		logic [15:0] addr;
	} dsa_trap_t;

endpackage

//--- testbench/dsa_sfr_model.sv
// register array model on the far side of the access unit's special register port
`timescale 1ns/1ps
module dsa_sfr_model (
	input wire logic clk_sys_in,
	input wire dsa_pkg::dsa_sfr_rd_t sfr_rd_in,
	input wire dsa_pkg::dsa_sfr_wr_t sfr_wr_in,
	output logic [15:0] sfr_rdata_out,
	output logic sfr_ack_out
);
	// ----------------------------------------
	// storage: only words 0x80..0x87 exist, all else unused
	// ----------------------------------------
	logic [15:0] regs_q [0:7];
	logic hit_rd;
	logic hit_wr;
	assign hit_rd = sfr_rd_in.en && (sfr_rd_in.word_addr[9:3] == 7'h10);
	assign hit_wr = (sfr_wr_in.word_addr[9:3] == 7'h10);
	initial
	begin
		sfr_rdata_out = 16'h0000;
		sfr_ack_out = 1'b0;
	end
	// lanes written on their own strobes; answer one cycle after enable
	always @(posedge clk_sys_in)
	begin
		if (hit_wr && sfr_wr_in.we_lo) regs_q[sfr_wr_in.word_addr[2:0]][7:0] <= sfr_wr_in.data[7:0];
		if (hit_wr && sfr_wr_in.we_hi) regs_q[sfr_wr_in.word_addr[2:0]][15:8] <= sfr_wr_in.data[15:8];
		sfr_ack_out <= hit_rd;
		// unused or idle: junk that flips, so a missing zero fill shows
		sfr_rdata_out <= hit_rd ? regs_q[sfr_rd_in.word_addr[2:0]] : ~sfr_rdata_out;
	end
endmodule // dsa_sfr_model

//--- testbench/tb_data_space_access_unit.sv
// self-checking bench for the data-space access unit
`timescale 1ns/1ps
module tb_data_space_access_unit;
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	dsa_pkg::dsa_rd_req_t rd_req = '0;
	dsa_pkg::dsa_wr_req_t wr_req = '0;
	dsa_pkg::dsa_rd_rsp_t rd_rsp;
	dsa_pkg::dsa_sfr_rd_t sfr_rd;
	dsa_pkg::dsa_sfr_wr_t sfr_wr;
	dsa_pkg::dsa_trap_t trap;
	logic [15:0] rd_ptr;
	logic [15:0] wr_ptr;
	logic [15:0] sfr_rdata;
	logic sfr_ack;
	int err_total = 0;
	int checks = 0;

	// ----------------------------------------
	// clock, design and register array
	// ----------------------------------------
	always #4 clk_sys_in = ~clk_sys_in;
	dsa_access_unit dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .rd_req_in(rd_req),
		.wr_req_in(wr_req), .rd_rsp_out(rd_rsp), .rd_ptr_next_out(rd_ptr),
		.wr_ptr_next_out(wr_ptr), .sfr_rd_out(sfr_rd), .sfr_rdata_in(sfr_rdata),
		.sfr_ack_in(sfr_ack), .sfr_wr_out(sfr_wr), .trap_out(trap));
	dsa_sfr_model u_sfr (.clk_sys_in(clk_sys_in), .sfr_rd_in(sfr_rd), .sfr_wr_in(sfr_wr),
		.sfr_rdata_out(sfr_rdata), .sfr_ack_out(sfr_ack));

	// ----------------------------------------
	// compare and transfer tasks
	// ----------------------------------------
	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_val({15'h0000, got}, {15'h0000, exp});
	endtask
	// one idle edge first, so a call never re-raises what the last one just dropped and
	// the register array has stored any write before it is read back; answer looked at in c1
	task automatic rd_go(input dsa_pkg::dsa_mode_t m, input logic [15:0] f, input logic byt,
		input dsa_pkg::dsa_ext_t x, input logic trp, input logic [15:0] ed, input logic [15:0] ew);
		@(posedge clk_sys_in);
		#1;
		rd_req = '{1'b1, m, f, 1'b1, byt, x, 16'h1234};
		#1;
		cmp_bit(trap.pulse, trp);
		if (trp) cmp_bit(trap.on_write, 1'b0);
		if (trp) cmp_val(trap.addr, f);
		@(posedge clk_sys_in);
		#1;
		rd_req = '0;
		cmp_bit(rd_rsp.valid, 1'b1);
		cmp_val(rd_rsp.data, ed);
		cmp_val(rd_rsp.wreg, ew);
	endtask
	task automatic wr_go(input dsa_pkg::dsa_mode_t m, input logic [15:0] f, input logic byt,
		input logic [15:0] d, input logic trp);
		@(posedge clk_sys_in);
		#1;
		wr_req = '{1'b1, m, f, 1'b1, byt, d};
		#1;
		cmp_bit(trap.pulse, trp);
		if (trp) cmp_val(trap.addr, f);
		if (trp) cmp_bit(trap.on_write, 1'b1);
		@(posedge clk_sys_in);
		#1;
		wr_req = '0;
	endtask
	task automatic finish_test;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_ram;
		wr_go(dsa_pkg::AM_DIRECT16, 16'h0800, 1'b0, 16'hA55A, 1'b0);
		cmp_val(wr_ptr, 16'h0802);
		rd_go(dsa_pkg::AM_INDIRECT, 16'h0800, 1'b0, dsa_pkg::EXT_NONE, 1'b0, 16'hA55A, 16'hA55A);
		cmp_val(rd_ptr, 16'h0802);
		rd_go(dsa_pkg::AM_INDIRECT, 16'h0801, 1'b1, dsa_pkg::EXT_NONE, 1'b0, 16'h00A5, 16'h12A5);
		cmp_val(rd_ptr, 16'h0802);
		wr_go(dsa_pkg::AM_INDIRECT, 16'h0800, 1'b1, 16'h003C, 1'b0);
		cmp_val(wr_ptr, 16'h0801);
		rd_go(dsa_pkg::AM_DIRECT16, 16'h0800, 1'b0, dsa_pkg::EXT_NONE, 1'b0, 16'hA53C, 16'hA53C);
	endtask
	// misaligned write dropped, misaligned read still answers
	task automatic t_align;
		wr_go(dsa_pkg::AM_DIRECT16, 16'h0802, 1'b0, 16'h1357, 1'b0);
		wr_go(dsa_pkg::AM_DIRECT16, 16'h0803, 1'b0, 16'hFFFF, 1'b1);
		rd_go(dsa_pkg::AM_DIRECT16, 16'h0803, 1'b0, dsa_pkg::EXT_NONE, 1'b1, 16'h1357, 16'h1357);
		cmp_val(rd_ptr, 16'h0805);
	endtask
	task automatic t_zero;
		rd_go(dsa_pkg::AM_DIRECT16, 16'h1000, 1'b0, dsa_pkg::EXT_NONE, 1'b0, 16'h0000, 16'h0000);
		rd_go(dsa_pkg::AM_DIRECT16, 16'h8000, 1'b0, dsa_pkg::EXT_NONE, 1'b0, 16'h0000, 16'h0000);
		cmp_val({14'h0000, rd_rsp.region}, {14'h0000, dsa_pkg::RGN_PSV});
	endtask
	task automatic t_ext;
		wr_go(dsa_pkg::AM_DIRECT16, 16'h0804, 1'b0, 16'h7F80, 1'b0);
		rd_go(dsa_pkg::AM_DIRECT16, 16'h0804, 1'b1, dsa_pkg::EXT_SIGN, 1'b0, 16'h0080, 16'hFF80);
		rd_go(dsa_pkg::AM_DIRECT16, 16'h0805, 1'b1, dsa_pkg::EXT_SIGN, 1'b0, 16'h007F, 16'h007F);
		rd_go(dsa_pkg::AM_DIRECT16, 16'h0804, 1'b1, dsa_pkg::EXT_ZERO, 1'b0, 16'h0080, 16'h0080);
	endtask
	task automatic t_sfr;
		wr_go(dsa_pkg::AM_NEAR13, 16'hE100, 1'b0, 16'hBEEF, 1'b0);
		cmp_val({sfr_wr.we_lo, sfr_wr.we_hi, 4'h0, sfr_wr.word_addr}, 16'hC080);
		wr_go(dsa_pkg::AM_DIRECT16, 16'h0101, 1'b1, 16'h0011, 1'b0);
		cmp_val({sfr_wr.we_lo, sfr_wr.we_hi, 4'h0, sfr_wr.word_addr}, 16'h4080);
		rd_go(dsa_pkg::AM_NEAR13, 16'hE100, 1'b0, dsa_pkg::EXT_NONE, 1'b0, 16'h11EF, 16'h11EF);
		cmp_val({14'h0000, rd_rsp.region}, {14'h0000, dsa_pkg::RGN_SFR});
		rd_go(dsa_pkg::AM_DIRECT16, 16'h0200, 1'b0, dsa_pkg::EXT_NONE, 1'b0, 16'h0000, 16'h0000);
	endtask
	// a write and a read taken on the same edge, first to two words, then to one word
	task automatic t_indep;
		@(posedge clk_sys_in);
		#1;
		wr_req = '{1'b1, dsa_pkg::AM_DIRECT16, 16'h0806, 1'b1, 1'b0, 16'h2468};
		rd_req = '{1'b1, dsa_pkg::AM_DIRECT16, 16'h0800, 1'b1, 1'b0, dsa_pkg::EXT_NONE, 16'h1234};
		@(posedge clk_sys_in);
		#1;
		wr_req = '0;
		rd_req = '0;
		cmp_val(rd_rsp.data, 16'hA53C);
		cmp_val(wr_ptr, 16'h0808);
		cmp_val(rd_ptr, 16'h0802);
		rd_go(dsa_pkg::AM_DIRECT16, 16'h0806, 1'b0, dsa_pkg::EXT_NONE, 1'b0, 16'h2468, 16'h2468);
		// same word on both sides: the read sees the word from before the write
		@(posedge clk_sys_in);
		#1;
		wr_req = '{1'b1, dsa_pkg::AM_DIRECT16, 16'h0806, 1'b0, 1'b0, 16'h9BDF};
		rd_req = '{1'b1, dsa_pkg::AM_DIRECT16, 16'h0806, 1'b0, 1'b0, dsa_pkg::EXT_NONE, 16'h1234};
		@(posedge clk_sys_in);
		#1;
		wr_req = '0;
		rd_req = '0;
		cmp_val(rd_rsp.data, 16'h2468);
		rd_go(dsa_pkg::AM_DIRECT16, 16'h0806, 1'b0, dsa_pkg::EXT_NONE, 1'b0, 16'h9BDF, 16'h9BDF);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (5) @(posedge clk_sys_in);
		#1;
		srst_in = 1'b0;
		@(posedge clk_sys_in);
		#1;
		cmp_val(rd_rsp.data | rd_ptr | wr_ptr, 16'h0000);
		t_ram();
		t_align();
		t_zero();
		t_ext();
		t_sfr();
		t_indep();
		finish_test();
	end
	// whole run needs under 100 cycles; far beyond that means a hang
	initial
	begin
		repeat (2000) @(posedge clk_sys_in);
		err_total++;
		finish_test();
	end
endmodule // tb_data_space_access_unit
